// *** modem_symbol_sync_qualifier.sv ***
/*
  Modem symbol mapper, line coder, sync qualifier and signal-strength /
  carrier-sense logic. Assumes the front end delivers chip strobes, sliced
  decisions and raw strength samples on ref_clk_i, already synchronous.
*/
`timescale 1ns/10ps

module modem_symbol_sync_qualifier
  import modem_sync_pkg::*;
#(
  parameter logic [31:0] SYNC_WORD = 32'hA5C3A5C3,  // Arbitrary default sync pattern.
  parameter int          HYST_HALF_DB = 2             // Release hysteresis in half-dB.
) (
  input  wire logic              ref_clk_i,        // 100 MHz clock.
  input  wire logic              arst_n_i,         // Async reset, active low.
  input  wire logic [3:0]        reg_addr_i,       // Register address.
  input  wire logic [7:0]        reg_wdata_i,      // Register write data.
  input  wire logic              reg_we_i,         // Write strobe.
  input  wire logic              reg_re_i,         // Read strobe.
  output logic      [7:0]        reg_rdata_o,      // Read data, cycle after strobe.
  input  wire logic              tx_chip_stb_i,    // One pulse per transmitted chip.
  input  wire logic [1:0]        tx_bits_i,        // Next data, bit 1 goes first.
  input  wire logic              tx_payload_i,     // High while payload is sent.
  output logic                   tx_take_o,        // Data consumed this cycle.
  output logic                   tx_take_pair_o,   // Both bits consumed.
  output logic signed [11:0]     freq_offset_o,    // Deviation step to synthesiser.
  output logic                   pa_on_o,          // Power amplifier enable.
  output logic      [10:0]       dev_word_o,       // Deviation in crystal/2^17 units.
  input  wire logic              rx_on_i,          // Receiver active.
  input  wire logic              rx_chip_stb_i,    // One pulse per received decision.
  input  wire logic [1:0]        rx_bits_i,        // Decision, bit 1 first.
  output logic                   rx_four_level_o,  // Demod should slice four levels.
  output logic                   rx_fifo_wr_o,     // Payload data to receive FIFO.
  output logic      [1:0]        rx_fifo_data_o,   // Payload data bits.
  output logic                   rx_fifo_pair_o,   // Both data bits valid.
  output logic                   rx_filter_en_o,   // Packet filtering allowed.
  output logic                   rx_code_err_o,    // Manchester chip pair invalid.
  input  wire logic              rssi_raw_stb_i,   // Raw strength sample strobe.
  input  wire logic signed [7:0] rssi_raw_i,       // Raw strength, half-dB.
  input  wire logic signed [7:0] cs_base_i,        // Threshold from gain limits.
  input  wire logic              pkt_end_i,        // End of received payload.
  output logic                   trailer_wr_o,     // Trailer strength byte valid.
  output logic      [7:0]        trailer_byte_o,   // Trailer strength byte.
  output logic                   carrier_sense_o,  // Carrier-sense flag.
  output logic                   gen_pin_o         // General-purpose output pin.
);

  // Refuse a hysteresis the signed threshold arithmetic cannot hold.
  if (HYST_HALF_DB < 0 || HYST_HALF_DB > 16) begin : g_bad_hyst
    $error("HYST_HALF_DB out of range");
  end

  // Reset release through two flip-flops.
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Software registers.
  logic [7:0] mdm_q, dev_q, agc0_q, agc1_q, agc2_q, pkt1_q, pin_q;
  logic       cs_q;
  logic       sync_seen_q;
  logic signed [7:0] strength_q;

  // Address decode.
  wire wr_mdm  = reg_we_i && (reg_addr_i == OFF_MODEM_CONFIG_TWO);
  wire wr_dev  = reg_we_i && (reg_addr_i == OFF_DEVIATION_SETTING);
  wire wr_agc0 = reg_we_i && (reg_addr_i == OFF_GAIN_CONTROL_ZERO);
  wire wr_agc1 = reg_we_i && (reg_addr_i == OFF_GAIN_CONTROL_ONE);
  wire wr_agc2 = reg_we_i && (reg_addr_i == OFF_GAIN_CONTROL_TWO);
  wire wr_pkt1 = reg_we_i && (reg_addr_i == OFF_PACKET_CONTROL_ONE);
  wire wr_pin  = reg_we_i && (reg_addr_i == OFF_OUTPUT_PIN_CONFIG);

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mdm_q  <= RST_MODEM_CONFIG_TWO;
      dev_q  <= RST_DEVIATION_SETTING;
      agc0_q <= RST_GAIN_CONTROL_ZERO;
      agc1_q <= RST_GAIN_CONTROL_ONE;
      agc2_q <= RST_GAIN_CONTROL_TWO;
      pkt1_q <= RST_PACKET_CONTROL_ONE;
      pin_q  <= RST_OUTPUT_PIN_CONFIG;
    end else begin
      if (wr_mdm)  mdm_q  <= reg_wdata_i;
      if (wr_dev)  dev_q  <= reg_wdata_i;
      if (wr_agc0) agc0_q <= reg_wdata_i;
      if (wr_agc1) agc1_q <= reg_wdata_i;
      if (wr_agc2) agc2_q <= reg_wdata_i;
      if (wr_pkt1) pkt1_q <= reg_wdata_i;
      if (wr_pin)  pin_q  <= reg_wdata_i;
    end
  end

  // Field extraction.
  wire [2:0] mod_fmt    = mdm_q[MOD_FORMAT_LSB +: 3];
  wire [2:0] sync_mode  = mdm_q[SYNC_MODE_LSB +: 3];
  wire [2:0] dev_exp    = dev_q[DEV_EXP_LSB +: 3];
  wire [2:0] dev_mant   = dev_q[DEV_MANT_LSB +: 3];
  wire [1:0] filt_len   = agc0_q[FILTER_LEN_LSB +: 2];
  wire [1:0] rel_sel    = agc1_q[REL_SEL_LSB +: 2];
  wire [3:0] abs_off    = agc1_q[ABS_OFF_LSB +: 4];
  wire       trailer_en = pkt1_q[TRAILER_EN_BIT];
  wire [5:0] pin_sel    = pin_q[PIN_SEL_LSB +: 6];
  wire       is_ook     = (mod_fmt == FMT_ON_OFF);
  wire       is_four    = (mod_fmt == FMT_FOUR_LVL);
  // four-level with Manchester is unsupported, so the coder is kept off there.
  wire       manch_on   = mdm_q[LINE_CODE_BIT] && !is_four;

  wire [3:0]  mant_full = 4'(DEV_MANT_BASE) + {1'b0, dev_mant};
  wire [10:0] dev_word  = 11'({7'h00, mant_full} << dev_exp);
  wire [10:0] dev_third = 11'(dev_word / 11'd3);
  assign dev_word_o = dev_word;

  // Status bits for the packet state register.
  wire [7:0] state_byte = 8'(({7'h00, cs_q} << STATE_CS_BIT)
                           | ({7'h00, sync_seen_q} << STATE_SYNC_BIT)
                           | ({7'h00, gen_pin_o} << STATE_PIN_BIT));

  // Read mux; unmapped offsets read as zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      OFF_MODEM_CONFIG_TWO:   rd_mux = mdm_q;
      OFF_DEVIATION_SETTING:  rd_mux = dev_q;
      OFF_GAIN_CONTROL_ZERO:  rd_mux = agc0_q;
      OFF_GAIN_CONTROL_ONE:   rd_mux = agc1_q;
      OFF_GAIN_CONTROL_TWO:   rd_mux = agc2_q;
      OFF_PACKET_CONTROL_ONE: rd_mux = pkt1_q;
      OFF_OUTPUT_PIN_CONFIG:  rd_mux = pin_q;
      OFF_PACKET_STATE:       rd_mux = state_byte;
      OFF_STRENGTH:           rd_mux = strength_q;
      OFF_DEV_WORD_LO:        rd_mux = dev_word[7:0];
      OFF_DEV_WORD_HI:        rd_mux = {5'h00, dev_word[10:8]};
      default:                rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) reg_rdata_o <= 8'h00;
    else          reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
  end

  // Transmit side: second half of a Manchester pair sends the held bit 1 inverted.
  logic       tx_half_q;
  logic [1:0] tx_hold_q;
  wire tx_four = is_four && tx_payload_i;
  // encoder takes data on first half
  assign tx_take_o      = tx_chip_stb_i && !(manch_on && tx_half_q);
  assign tx_take_pair_o = tx_take_o && tx_four;
  wire [1:0] tx_sym = tx_take_o ? tx_bits_i : {~tx_hold_q[1], tx_hold_q[0]};

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_half_q <= 1'b0;
      tx_hold_q <= 2'b00;
    end else if (tx_chip_stb_i) begin
      tx_half_q <= manch_on ? !tx_half_q : 1'b0;
      tx_hold_q <= tx_sym;
    end
  end

  logic signed [11:0] freq_d;
  always_comb begin
    if (!tx_four) begin
      freq_d = tx_sym[1] ? $signed({1'b0, dev_word}) : -$signed({1'b0, dev_word});
    end else begin
      case (tx_sym)
        2'b01:   freq_d = -$signed({1'b0, dev_word});
        2'b00:   freq_d = -$signed({1'b0, dev_third});
        2'b10:   freq_d = $signed({1'b0, dev_third});
        default: freq_d = $signed({1'b0, dev_word});
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      freq_offset_o <= 12'sh000;
      pa_on_o       <= 1'b0;
    end else if (tx_chip_stb_i) begin
      freq_offset_o <= is_ook ? 12'sh000 : freq_d;
      pa_on_o       <= is_ook ? tx_sym[1] : 1'b1;
    end
  end

  // Receive side: entry into receive restarts pairing, search and freeze.
  logic rx_on_q;
  wire  rx_enter = rx_on_i && !rx_on_q;
  logic rx_half_q;
  logic rx_first_q;
  logic [LONG_BITS-1:0] shift_q;

  wire rx_bit_stb = rx_chip_stb_i && !(manch_on && !rx_half_q);
  wire rx_bit     = manch_on ? rx_first_q : rx_bits_i[1];
  wire [LONG_BITS-1:0] shift_d = {shift_q[LONG_BITS-2:0], rx_bit};

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_on_q       <= 1'b0;
      rx_half_q     <= 1'b0;
      rx_first_q    <= 1'b0;
      rx_code_err_o <= 1'b0;
      shift_q       <= '0;
    end else begin
      rx_on_q <= rx_on_i;
      if (rx_enter) begin
        rx_half_q     <= 1'b0;
        rx_code_err_o <= 1'b0;
        shift_q       <= '0;
      end else if (rx_chip_stb_i) begin
        rx_half_q  <= manch_on ? !rx_half_q : 1'b0;
        rx_first_q <= rx_bits_i[1];
        rx_code_err_o <= manch_on && rx_half_q && (rx_bits_i[1] == rx_first_q);
        if (rx_bit_stb && !sync_seen_q) shift_q <= shift_d;
      end
    end
  end

  // Mismatch counting across the search window.
  function automatic logic [5:0] ones32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + 6'(v[i]);
    end
    return n;
  endfunction

  wire [LONG_BITS-1:0] diff = shift_d ^ SYNC_WORD;
  wire [5:0] err_short = ones32({16'h0000, diff[SHORT_BITS-1:0]});
  wire [5:0] err_long  = ones32(diff);

  logic hit;
  always_comb begin
    case (sync_mode[1:0])
      2'b01:   hit = (err_short <= 6'(ERR_SHORT));
      2'b10:   hit = (err_short == 6'h00);
      2'b11:   hit = (err_long <= 6'(ERR_LONG));
      default: hit = 1'b0;
    endcase
  end

  wire cs_ok      = !sync_mode[2] || cs_q;
  wire searching  = (sync_mode[1:0] != 2'b00);
  wire sync_found = rx_on_i && searching && rx_bit_stb && !sync_seen_q && hit && cs_ok;

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q)        sync_seen_q <= 1'b0;
    else if (rx_enter)   sync_seen_q <= 1'b0;
    else if (sync_found) sync_seen_q <= 1'b1;
  end

  wire rx_open = rx_on_i && (searching ? sync_seen_q : cs_ok);
  assign rx_filter_en_o = rx_open;
  assign rx_four_level_o = is_four && sync_seen_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_fifo_wr_o   <= 1'b0;
      rx_fifo_data_o <= 2'b00;
      rx_fifo_pair_o <= 1'b0;
    end else begin
      rx_fifo_wr_o <= rx_open && rx_bit_stb;
      if (rx_bit_stb) begin
        rx_fifo_data_o <= rx_four_level_o ? rx_bits_i : {rx_bit, 1'b0};
        rx_fifo_pair_o <= rx_four_level_o;
      end
    end
  end

  logic [2:0]         avg_cnt_q;
  logic signed [10:0] acc_q;
  wire  [2:0]         avg_last = 3'((4'h1 << filt_len) - 4'h1);
  wire  signed [10:0] acc_d    = acc_q + 11'(rssi_raw_i);
  wire  signed [7:0]  avg_val  = 8'(acc_d >>> filt_len);
  wire                upd      = rssi_raw_stb_i && (avg_cnt_q == avg_last);

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avg_cnt_q <= 3'h0;
      acc_q     <= 11'sh000;
    end else if (rx_enter || upd) begin
      avg_cnt_q <= 3'h0;
      acc_q     <= 11'sh000;
    end else if (rssi_raw_stb_i) begin
      avg_cnt_q <= avg_cnt_q + 3'h1;
      acc_q     <= acc_d;
    end
  end

  // signed half-dB byte kept as is
  logic signed [7:0] last_q;
  logic signed [7:0] prev_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strength_q <= 8'sh80;
      last_q     <= 8'sh80;
      prev_q     <= 8'sh80;
    end else if (upd && rx_on_i) begin
      if (!(searching && sync_seen_q)) strength_q <= avg_val;
      last_q <= avg_val;
      prev_q <= avg_val;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trailer_wr_o   <= 1'b0;
      trailer_byte_o <= 8'h00;
    end else begin
      trailer_wr_o <= pkt_end_i && trailer_en;
      if (pkt_end_i && trailer_en) trailer_byte_o <= last_q;
    end
  end

  wire signed [9:0] abs_thr  = 10'(cs_base_i) + 10'($signed(abs_off)) * 10'(HALF_DB_PER_DB);
  wire signed [9:0] abs_rel  = abs_thr - 10'(HYST_HALF_DB);
  wire signed [9:0] val_ext  = 10'(avg_val);
  wire              abs_on   = (abs_off != ABS_OFF_DISABLED);

  logic [9:0] rel_step;
  always_comb begin
    case (rel_sel)
      2'b01:   rel_step = 10'(REL_STEP_A_DB * HALF_DB_PER_DB);
      2'b10:   rel_step = 10'(REL_STEP_B_DB * HALF_DB_PER_DB);
      2'b11:   rel_step = 10'(REL_STEP_C_DB * HALF_DB_PER_DB);
      default: rel_step = 10'h000;
    endcase
  end
  wire signed [9:0] delta = val_ext - 10'(prev_q);

  // Either enabled detector can raise the flag; a disabled one stays low.
  logic abs_st_q;
  logic rel_st_q;
  logic abs_st_d;
  logic rel_st_d;
  always_comb begin
    abs_st_d = abs_st_q;
    rel_st_d = rel_st_q;
    if (!abs_on)                abs_st_d = 1'b0;
    else if (val_ext > abs_thr) abs_st_d = 1'b1;
    else if (val_ext < abs_rel) abs_st_d = 1'b0;
    if (rel_sel == 2'b00)                       rel_st_d = 1'b0;
    else if (delta >= $signed(rel_step))        rel_st_d = 1'b1;
    else if (delta <= -$signed(rel_step))       rel_st_d = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      abs_st_q <= 1'b0;
      rel_st_q <= 1'b0;
      cs_q     <= 1'b0;
    end else if (!rx_on_i) begin
      abs_st_q <= 1'b0;
      rel_st_q <= 1'b0;
      cs_q     <= 1'b0;
    end else if (upd) begin
      abs_st_q <= abs_st_d;
      rel_st_q <= rel_st_d;
      cs_q     <= abs_st_d || rel_st_d;
    end
  end

  assign carrier_sense_o = cs_q;
  assign gen_pin_o = (pin_sel == PIN_SEL_CS)   ? cs_q :
                     (pin_sel == PIN_SEL_SYNC) ? sync_seen_q : 1'b0;

endmodule // modem_symbol_sync_qualifier

// *** modem_sync_pkg.sv ***
/*
  Shared constants for the modem symbol and sync qualifier block: register
  offsets, field positions, reset values, mode codes and counts.
  Assumes a single clock domain and an 8-bit register port.
*/
package modem_sync_pkg;

  // Register offsets on the 4-bit register port.
  localparam logic [3:0] OFF_MODEM_CONFIG_TWO   = 4'h0;
  localparam logic [3:0] OFF_DEVIATION_SETTING  = 4'h1;
  localparam logic [3:0] OFF_GAIN_CONTROL_ZERO  = 4'h2;
  localparam logic [3:0] OFF_GAIN_CONTROL_ONE   = 4'h3;
  localparam logic [3:0] OFF_GAIN_CONTROL_TWO   = 4'h4;
  localparam logic [3:0] OFF_PACKET_CONTROL_ONE = 4'h5;
  localparam logic [3:0] OFF_OUTPUT_PIN_CONFIG  = 4'h6;
  localparam logic [3:0] OFF_PACKET_STATE       = 4'h7;
  localparam logic [3:0] OFF_STRENGTH           = 4'h8;
  localparam logic [3:0] OFF_DEV_WORD_LO        = 4'h9;
  localparam logic [3:0] OFF_DEV_WORD_HI        = 4'hA;

  // Field positions.
  localparam int MOD_FORMAT_LSB   = 4;   // modem_config_two[6:4]
  localparam int LINE_CODE_BIT    = 3;   // modem_config_two[3]
  localparam int SYNC_MODE_LSB    = 0;   // modem_config_two[2:0]
  localparam int DEV_EXP_LSB      = 4;   // deviation_setting[6:4]
  localparam int DEV_MANT_LSB     = 0;   // deviation_setting[2:0]
  localparam int FILTER_LEN_LSB   = 0;   // gain_control_zero[1:0]
  localparam int REL_SEL_LSB      = 4;   // gain_control_one[5:4]
  localparam int ABS_OFF_LSB      = 0;   // gain_control_one[3:0]
  localparam int TRAILER_EN_BIT   = 2;   // packet_control_one[2]
  localparam int PIN_SEL_LSB      = 0;   // output_pin_config[5:0]
  localparam int STATE_CS_BIT     = 6;   // packet_state_register[6]
  localparam int STATE_SYNC_BIT   = 3;   // packet_state_register[3]
  localparam int STATE_PIN_BIT    = 0;   // packet_state_register[0]

  // Reset values.
  localparam logic [7:0] RST_MODEM_CONFIG_TWO   = 8'h02;
  localparam logic [7:0] RST_DEVIATION_SETTING  = 8'h47;
  localparam logic [7:0] RST_GAIN_CONTROL_ZERO  = 8'h01;
  localparam logic [7:0] RST_GAIN_CONTROL_ONE   = 8'h00;  // Offset field 0 means 0 dB.
  localparam logic [7:0] RST_GAIN_CONTROL_TWO   = 8'h03;
  localparam logic [7:0] RST_PACKET_CONTROL_ONE = 8'h04;
  localparam logic [7:0] RST_OUTPUT_PIN_CONFIG  = 8'h00;

  // Modulation format codes.
  localparam logic [2:0] FMT_TWO_LEVEL = 3'h0;
  localparam logic [2:0] FMT_GAUSSIAN  = 3'h1;
  localparam logic [2:0] FMT_ON_OFF    = 3'h3;
  localparam logic [2:0] FMT_FOUR_LVL  = 3'h4;

  // Deviation mantissa base and output pin select codes.
  localparam int         DEV_MANT_BASE = 8;
  localparam logic [5:0] PIN_SEL_SYNC  = 6'h06;
  localparam logic [5:0] PIN_SEL_CS    = 6'h0E;  // Decimal 14.

  // Carrier-sense steps in dB, scaled to the half-dB units of the strength byte.
  localparam logic [3:0] ABS_OFF_DISABLED = 4'h8;  // Most negative code turns absolute sense off.
  localparam int         HALF_DB_PER_DB   = 2;
  localparam int         REL_STEP_A_DB    = 6;
  localparam int         REL_STEP_B_DB    = 10;
  localparam int         REL_STEP_C_DB    = 14;

  // Sync search lengths and allowed mismatches.
  localparam int SHORT_BITS = 16;
  localparam int LONG_BITS  = 32;
  localparam int ERR_SHORT  = 1;
  localparam int ERR_LONG   = 2;

endpackage

// *** modem_sync_chk.sv ***
/*
  Port checks for the modem symbol and sync qualifier block.
  Assumes it is bound to that block and sees only its ports.
*/
`timescale 1ns/10ps
module modem_sync_chk
  import modem_sync_pkg::*;
(
  input wire logic               ref_clk_i,       // Clock.
  input wire logic               arst_n_i,        // Reset, low.
  input wire logic [3:0]         reg_addr_i,      // Address.
  input wire logic [7:0]         reg_wdata_i,     // Write data.
  input wire logic               reg_we_i,        // Write strobe.
  input wire logic               tx_chip_stb_i,   // Chip strobe.
  input wire logic [1:0]         tx_bits_i,       // Data to send.
  input wire logic               tx_take_o,       // Data taken.
  input wire logic signed [11:0] freq_offset_o,   // Frequency step.
  input wire logic               pa_on_o,         // Amplifier on.
  input wire logic [10:0]        dev_word_o,      // Deviation word.
  input wire logic               rx_on_i,         // Receiver on.
  input wire logic               rx_fifo_wr_o,    // FIFO write.
  input wire logic               rx_filter_en_o,  // Receive open.
  input wire logic               rssi_raw_stb_i,  // Raw sample.
  input wire logic               pkt_end_i,       // Payload end.
  input wire logic               trailer_wr_o,    // Trailer write.
  input wire logic               carrier_sense_o, // Carrier sense.
  input wire logic               gen_pin_o        // Output pin.
);
  logic [7:0]              mc_q, dv_q, pc_q, pin_q;
  wire logic [2:0]         fmt = mc_q[6:4];
  wire logic signed [11:0] dev = signed'({1'b0, dev_word_o});

  // Shadow the mode registers so each check knows the configuration.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mc_q <= RST_MODEM_CONFIG_TWO;
      dv_q <= RST_DEVIATION_SETTING;
      pc_q <= RST_PACKET_CONTROL_ONE;
      pin_q <= RST_OUTPUT_PIN_CONFIG;
    end else if (reg_we_i) begin
      mc_q <= (reg_addr_i == OFF_MODEM_CONFIG_TWO) ? reg_wdata_i : mc_q;
      dv_q <= (reg_addr_i == OFF_DEVIATION_SETTING) ? reg_wdata_i : dv_q;
      pc_q <= (reg_addr_i == OFF_PACKET_CONTROL_ONE) ? reg_wdata_i : pc_q;
      pin_q <= (reg_addr_i == OFF_OUTPUT_PIN_CONFIG) ? reg_wdata_i : pin_q;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_dev_word: assert property (
    dev_word_o == (11'(DEV_MANT_BASE) + 11'(dv_q[2:0])) << dv_q[6:4]) else $error("bad deviation");
  chk_fsk_level: assert property (
    tx_take_o && fmt == FMT_TWO_LEVEL |=> freq_offset_o == ($past(tx_bits_i[1]) ? dev : -dev))
    else $error("bad two-level step");
  chk_manch_invert: assert property (
    tx_chip_stb_i && !tx_take_o && fmt == FMT_TWO_LEVEL |=> freq_offset_o == -$past(freq_offset_o))
    else $error("second chip not inverted");
  chk_ook_amp: assert property (
    tx_take_o && fmt == FMT_ON_OFF |=> pa_on_o == $past(tx_bits_i[1])) else $error("bad amp state");
  chk_no_early_wr: assert property (
    rx_fifo_wr_o |-> $past(rx_filter_en_o)) else $error("write before sync");
  chk_pin_sense: assert property (
    pin_q[5:0] == PIN_SEL_CS |-> gen_pin_o == carrier_sense_o) else $error("pin not sense");
  chk_trailer_pulse: assert property (
    trailer_wr_o == $past(pkt_end_i && pc_q[TRAILER_EN_BIT])) else $error("bad trailer pulse");
  chk_cs_on_update: assert property (
    $changed(carrier_sense_o) |-> $past(rssi_raw_stb_i) || $past(rssi_raw_stb_i, 2) ||
    !$past(rx_on_i)) else $error("sense changed without sample");
endmodule // modem_sync_chk

bind modem_symbol_sync_qualifier modem_sync_chk chk_u (.*);

// *** rf_front_end_model.sv ***
/*
  Behavioural front end: demodulated decisions and raw strength samples.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
module rf_front_end_model (
  input  wire logic        clk_i,      // Block clock.
  output logic             chip_stb_o, // Decision strobe.
  output logic [1:0]       bits_o,     // Decision value.
  output logic             rssi_stb_o, // Sample strobe.
  output logic signed [7:0] rssi_o     // Raw strength.
);
  // Idle lines start at zero; after each task they carry the inverse so stale values never pass for data.
  initial begin
    chip_stb_o = 1'b0;
    bits_o = 2'h0;
    rssi_stb_o = 1'b0;
    rssi_o = 8'h00;
  end

  task automatic send_bit(input logic b);
    @(posedge clk_i);
    chip_stb_o <= 1'b1;
    bits_o <= {b, 1'b0};
    @(posedge clk_i);
    chip_stb_o <= 1'b0;
    bits_o <= {~b, 1'b1};
  endtask

  // One raw sample, held for a single strobe.
  task automatic send_rssi(input logic [7:0] v);
    @(posedge clk_i);
    rssi_stb_o <= 1'b1;
    rssi_o <= v;
    @(posedge clk_i);
    rssi_stb_o <= 1'b0;
    rssi_o <= ~v;
  endtask
endmodule // rf_front_end_model

// *** tb_top.sv ***
/*
  Self-checking bench for the modem qualifier block.
  Assumes the package, block, checker and front-end model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import modem_sync_pkg::*;
  localparam logic [31:0] SYNC = 32'h5A3C96E1; // Arbitrary sync pattern.
  typedef struct {logic [2:0] m; int n; logic [31:0] x;} rx_case_s;
  logic ref_clk_i, arst_n_i, reg_we_i, reg_re_i, tx_chip_stb_i, tx_payload_i, rx_on_i, pkt_end_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, trailer_byte_o;
  logic [1:0] tx_bits_i, rx_bits_i, rx_fifo_data_o;
  logic signed [7:0] rssi_raw_i, cs_base_i;
  logic signed [11:0] freq_offset_o, d;
  logic [10:0] dev_word_o, e;
  logic tx_take_o, tx_take_pair_o, pa_on_o, rx_four_level_o, rx_fifo_wr_o, rx_fifo_pair_o;
  logic rx_filter_en_o, rx_code_err_o, rssi_raw_stb_i, rx_chip_stb_i, trailer_wr_o;
  logic carrier_sense_o, gen_pin_o;
  int errors = 0;
  int comparisons = 0;
  int nwr = 0;
  int h;
  logic [7:0] dv[3] = '{8'h00, 8'h77, 8'h35};
  rx_case_s tbl[4] = '{'{3'h0, 0, 32'h0}, '{3'h1, 16, 32'h100}, '{3'h2, 16, 32'h0},
                       '{3'h3, 32, 32'h10004}};

  modem_symbol_sync_qualifier #(.SYNC_WORD(SYNC)) dut_u (.*);
  rf_front_end_model fe_u (.clk_i(ref_clk_i), .chip_stb_o(rx_chip_stb_i), .bits_o(rx_bits_i),
                           .rssi_stb_o(rssi_raw_stb_i), .rssi_o(rssi_raw_i));

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    @(posedge ref_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1;
    cmp(12'(reg_rdata_o & m), 12'(x & m), "read");
  endtask
  task automatic txs(input logic [1:0] b);
    @(posedge ref_clk_i);
    tx_chip_stb_i <= 1'b1;
    tx_bits_i <= b;
    @(posedge ref_clk_i);
    tx_chip_stb_i <= 1'b0;
    #1;
  endtask
  task automatic smp(input logic [7:0] v, input logic c);
    fe_u.send_rssi(v);
    repeat (2) @(posedge ref_clk_i);
    #1;
    cmp(12'(carrier_sense_o), 12'(c), "carrier sense");
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Free-running clock and FIFO write counter.
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (rx_fifo_wr_o === 1'b1) nwr++;
  end
  // Watchdog, well beyond the few hundred cycles the tests need.
  initial begin
    #300000;
    errors++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {arst_n_i, reg_we_i, reg_re_i, tx_chip_stb_i, tx_payload_i, rx_on_i, pkt_end_i} = 7'h00;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    tx_bits_i = 2'h0;
    cs_base_i = 8'hD8; // Threshold of -40 half-dB.
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(OFF_MODEM_CONFIG_TWO, RST_MODEM_CONFIG_TWO);
    rd(OFF_GAIN_CONTROL_ONE, RST_GAIN_CONTROL_ONE);
    wr(OFF_STRENGTH, 8'h11);
    rd(OFF_STRENGTH, 8'h80);
    rd(4'hF, 8'h00);
    foreach (dv[i]) begin
      wr(OFF_DEVIATION_SETTING, dv[i]);
      #1;
      e = (11'(DEV_MANT_BASE) + 11'(dv[i][2:0])) << dv[i][6:4];
      cmp(12'(dev_word_o), 12'(e), "deviation word");
      rd(OFF_DEV_WORD_LO, e[7:0]);
      rd(OFF_DEV_WORD_HI, {5'h00, e[10:8]});
    end
    d = signed'({1'b0, e});
    $display("test registers done");
    wr(OFF_MODEM_CONFIG_TWO, 8'h02);
    txs(2'h2);
    cmp(freq_offset_o, d, "two-level one");
    txs(2'h0);
    cmp(freq_offset_o, -d, "two-level zero");
    wr(OFF_MODEM_CONFIG_TWO, 8'h0A);
    txs(2'h2);
    cmp(freq_offset_o, d, "first chip");
    txs(2'h2);
    cmp(freq_offset_o, -d, "second chip");
    wr(OFF_MODEM_CONFIG_TWO, 8'h42);
    tx_payload_i <= 1'b1;
    txs(2'h1);
    cmp(freq_offset_o, -d, "dibit 01");
    txs(2'h3);
    cmp(freq_offset_o, d, "dibit 11");
    txs(2'h2);
    cmp(12'(freq_offset_o > 0 && freq_offset_o < d), 12'h001, "dibit 10");
    tx_payload_i <= 1'b0;
    wr(OFF_MODEM_CONFIG_TWO, 8'h32);
    txs(2'h2);
    cmp(12'(pa_on_o), 12'h001, "amp on");
    txs(2'h0);
    cmp(12'(pa_on_o), 12'h000, "amp off");
    cmp(freq_offset_o, 12'h000, "no deviation");
    $display("test transmit done");
    wr(OFF_GAIN_CONTROL_ZERO, 8'h00);
    wr(OFF_OUTPUT_PIN_CONFIG, {2'h0, PIN_SEL_CS});
    rx_on_i <= 1'b1;
    smp(8'hF0, 1'b1);
    rd(OFF_STRENGTH, 8'hF0);
    rd(OFF_PACKET_STATE, 8'h40, 8'h40);
    cmp(12'(gen_pin_o), 12'h001, "pin");
    smp(8'hC4, 1'b0);
    wr(OFF_GAIN_CONTROL_ONE, 8'h07);
    smp(8'hE2, 1'b0);
    smp(8'hEC, 1'b1);
    for (int s = 0; s < 4; s++) begin
      h = 2 * ((s == 1) ? REL_STEP_A_DB : (s == 2) ? REL_STEP_B_DB : REL_STEP_C_DB);
      wr(OFF_GAIN_CONTROL_ONE, {2'h0, 2'(s), ABS_OFF_DISABLED});
      smp(8'hB0, 1'b0);
      smp(8'(8'hB0 + h - 1), 1'b0);
      smp(8'(8'hB0 + 2 * h - 1), s != 0);
    end
    $display("test carrier sense done");
    foreach (tbl[i]) begin
      wr(OFF_MODEM_CONFIG_TWO, {5'h00, tbl[i].m});
      @(posedge ref_clk_i);
      rx_on_i <= 1'b0;
      @(posedge ref_clk_i);
      rx_on_i <= 1'b1;
      fe_u.send_rssi(8'hCE);
      nwr = 0;
      for (int b = tbl[i].n - 1; b >= 0; b--) begin
        fe_u.send_bit(SYNC[b] ^ tbl[i].x[b]);
      end
      #1;
      cmp(12'(nwr), 12'h000, "early write");
      fe_u.send_bit(1'b1);
      fe_u.send_rssi(8'h30);
      rd(OFF_STRENGTH, (tbl[i].n == 0) ? 8'h30 : 8'hCE);
      cmp(12'(nwr), 12'h001, "payload write");
    end
    @(posedge ref_clk_i);
    pkt_end_i <= 1'b1;
    @(posedge ref_clk_i);
    pkt_end_i <= 1'b0;
    #1;
    cmp(12'(trailer_wr_o), 12'h001, "trailer strobe");
    cmp(12'(trailer_byte_o), 12'h030, "trailer byte");
    $display("test receive done");
    stop_test();
  end
endmodule // tb_top
